/* File: common/pps_pkg.sv */
// shared constants and carrier types for the pump pressure supervisor
// assumes a 125 MHz core clock and a 32-bit apb master
package pps_pkg;

    // ========================================
    // clock and timing
    localparam int unsigned CLK_KHZ  = 125000;  // core clock in khz
    localparam int unsigned TICK_MS  = 100;     // supervision tick, 0.1 s
    localparam int unsigned TICK_CYC = TICK_MS * CLK_KHZ; // cycles per tick

    // ========================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_SETP   = 8'h04;
    localparam logic [7:0] OFS_MAXP   = 8'h08;
    localparam logic [7:0] OFS_XFS    = 8'h0c;
    localparam logic [7:0] OFS_TOL    = 8'h10;
    localparam logic [7:0] OFS_SLPF   = 8'h14;
    localparam logic [7:0] OFS_SLPT   = 8'h18;
    localparam logic [7:0] OFS_HILIM  = 8'h1c;
    localparam logic [7:0] OFS_LOLIM  = 8'h20;
    localparam logic [7:0] OFS_HIWT   = 8'h24;
    localparam logic [7:0] OFS_HIST   = 8'h28;
    localparam logic [7:0] OFS_LOWT   = 8'h2c;
    localparam logic [7:0] OFS_LOST   = 8'h30;
    localparam logic [7:0] OFS_LOSST  = 8'h34;
    localparam logic [7:0] OFS_LOSSP  = 8'h38;
    localparam logic [7:0] OFS_GAIN   = 8'h3c;
    localparam logic [7:0] OFS_STAT   = 8'h40;

    // ========================================
    // control register fields
    localparam int CTL_RUN  = 0;   // motor running
    localparam int CTL_PCT  = 1;   // 1 = percent units
    localparam int CTL_FHI  = 2;   // max output freq above 300 hz
    localparam int CTL_HSEL = 4;   // 2-bit high pressure selection
    localparam int CTL_LSEL = 6;   // 2-bit low pressure selection
    localparam int CTL_PSEL = 8;   // 2-bit loss selection

    // gain register fields, 10 bits each
    localparam int GAIN_KP = 0;
    localparam int GAIN_TI = 10;
    localparam int GAIN_TD = 20;

    // status bit positions
    localparam int ST_HW   = 0;
    localparam int ST_HF   = 1;
    localparam int ST_LW   = 2;
    localparam int ST_LF   = 3;
    localparam int ST_PW   = 4;
    localparam int ST_PF   = 5;
    localparam int ST_SLP  = 6;
    localparam int ST_RAIS = 7;
    localparam int ST_LOWR = 8;
    localparam int ST_STIM = 9;

    // ========================================
    // selection codes and scaling
    localparam logic [1:0]  SEL_OFF  = 2'h0;
    localparam logic [1:0]  SEL_WARN = 2'h1;
    localparam logic [1:0]  SEL_BOTH = 2'h2;
    localparam logic [23:0] PCT_DIV  = 24'h000064; // percent scale
    localparam logic [25:0] PROM_DIV = 26'h00003e8; // per-mille scale
    localparam logic [15:0] FRES_HI  = 16'h000a; // 0.1 hz in 0.01 hz steps

    // ========================================
    // reset values
    localparam logic [15:0] RST_XFS  = 16'h03e8; // 10.00 full scale
    localparam logic [15:0] RST_MAXP = 16'h03e8;

    // ========================================
    // carriers
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pps_apb_req_t;

    typedef struct packed {
        logic [9:0] kp;   // 0.01 steps
        logic [9:0] ti;   // 0.1 s steps
        logic [9:0] td;   // 0.01 s steps
    } pps_gain_t;

endpackage : pps_pkg

/* File: core/pps_supervisor.sv */
// pump pressure supervisor: apb registers, sleep/wake, pressure alarms
// assumes feedback arrives asynchronously; output frequency is on core_clk_i
// Function
// RULE1 - gain settings change while motor runs
// RULE2 - feedback above setpoint lowers frequency
// RULE3 - below setpoint minus tolerance raises frequency
// RULE4 - below sleep frequency starts sleep timing
// RULE5 - sleep delay done: decelerate, then sleep
// RULE6 - above 300 hz, 0.1 hz frequency steps
// RULE7 - sleep frequency used by pump only
// RULE8 - regulation target held between pressure limits
// RULE9 - unit select: pressure or percent
// RULE10 - high pressure warning timer
// RULE11 - high pressure stop timer and fault
// RULE12 - high selection: off, warn, warn+fault
// RULE13 - low pressure warning timer
// RULE14 - low pressure stop timer and fault
// RULE15 - low selection: off, warn, warn+fault
// RULE16 - loss detect off if proportion/select zero
// RULE17 - feedback below setpoint share raises loss
// RULE18 - loss selection: off, warning, error
// RULE19 - setpoint clamped to max, max to span
// RULE20 - timers tick 0.1 s, clear on stop
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module pps_supervisor #(
    parameter int unsigned TICK_CYC = pps_pkg::TICK_CYC  // cycles per tick
) (
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_b_i,
    // apb slave
    input  wire pps_pkg::pps_apb_req_t apb_i,
    output logic [31:0]                prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    // plant side
    input  wire logic [15:0]           fb_press_i,
    input  wire logic [15:0]           out_freq_i,
    // regulation commands
    output logic                       freq_lower_o,
    output logic                       freq_raise_o,
    output logic                       decel_sleep_o,
    output logic                       pump_sleep_o,
    output logic                       drive_stop_o,
    output logic [15:0]                reg_target_o,
    output pps_pkg::pps_gain_t         gain_o,
    // alarms
    output logic                       high_pressure_warning_flag_o,
    output logic                       high_pressure_stop_fault_o,
    output logic                       low_pressure_warning_flag_o,
    output logic                       low_pressure_stop_fault_o,
    output logic                       loss_warn_o,
    output logic                       loss_of_pressure_fault_o
);

    // ========================================
    // state types
    typedef enum logic [1:0] {
        SLP_RUN   = 2'b00,  // regulating
        SLP_WAIT  = 2'b01,  // timing sleep delay
        SLP_DECEL = 2'b10,  // ramping down
        SLP_IDLE  = 2'b11   // asleep
    } pps_slp_t;

    typedef struct packed {
        logic [9:0]        ctrl;
        logic [15:0]       setp, maxp, xfs, tol, slpf, hilim, lolim;
        logic [5:0][12:0]  tlim;    // timer limits, 0.1 s
        logic [9:0]        lossp;   // 0.1 % steps
        pps_pkg::pps_gain_t gain;
        logic [23:0]       tick_cnt;
        logic [5:0][12:0]  tmr;     // running timers
        logic [15:0]       fb_s1, fb_s2;
        pps_slp_t          slp;
        logic              hw, hf, lw, lf, pw, pf;
        logic              lower, raise, decel, stop;
        logic [15:0]       target;
        logic [31:0]       prdata;
        logic              pready, pslverr;
    } pps_state_t;

    // timer slots
    localparam int T_HW = 0;
    localparam int T_HS = 1;
    localparam int T_LW = 2;
    localparam int T_LS = 3;
    localparam int T_PL = 4;
    localparam int T_SL = 5;

    pps_state_t s_q, s_d;

    // ========================================
    // combinational helpers
    logic        tick;
    logic [15:0] fb, eff_max, eff_sp, eff_tol, eff_hi, eff_lo, wake_lvl;
    logic [25:0] loss_thr;
    logic        above, below, lossc, run, pct, hit, wr, setup, clr_ok;
    logic [1:0]  hsel, lsel, psel;
    logic [5:0]  cond, expd;
    logic [31:0] rd;
    logic [31:0] wd;
    logic [15:0] wd16;

    // ========================================
    // next-state logic
    always_comb begin
        s_d   = s_q;
        wd    = apb_i.pwdata;
        wd16  = wd[15:0];
        run   = s_q.ctrl[pps_pkg::CTL_RUN];
        pct   = s_q.ctrl[pps_pkg::CTL_PCT];
        hsel  = s_q.ctrl[pps_pkg::CTL_HSEL +: 2];
        lsel  = s_q.ctrl[pps_pkg::CTL_LSEL +: 2];
        psel  = s_q.ctrl[pps_pkg::CTL_PSEL +: 2];

        // tick divider; counts above 4096 so it is a parameter
        tick = (s_q.tick_cnt == 24'(TICK_CYC - 1));  // [RULE20]
        s_d.tick_cnt = tick ? 24'h000000 : s_q.tick_cnt + 24'h000001;

        // two-flop feedback synchroniser
        s_d.fb_s1 = fb_press_i;
        s_d.fb_s2 = s_q.fb_s1;
        fb = s_q.fb_s2;

        // clamp chain: span bounds max, max bounds setpoint
        eff_max = (s_q.maxp > s_q.xfs) ? s_q.xfs : s_q.maxp;  // [RULE19]
        eff_sp  = (s_q.setp > eff_max) ? eff_max : s_q.setp;  // [RULE19]

        // percent mode scales tolerance by setpoint, limits by span
        eff_tol = pct ? 16'((24'(s_q.tol[6:0]) * 24'(eff_sp)) / pps_pkg::PCT_DIV)
                      : s_q.tol;                               // [RULE9]
        eff_hi  = pct ? 16'((24'(s_q.hilim[6:0]) * 24'(s_q.xfs)) / pps_pkg::PCT_DIV)
                      : s_q.hilim;                             // [RULE9]
        eff_lo  = pct ? 16'((24'(s_q.lolim[6:0]) * 24'(s_q.xfs)) / pps_pkg::PCT_DIV)
                      : s_q.lolim;                             // [RULE9]
        wake_lvl = (eff_sp > eff_tol) ? eff_sp - eff_tol : 16'h0000;
        loss_thr = (26'(eff_sp) * 26'(s_q.lossp)) / pps_pkg::PROM_DIV;

        above = fb > eff_hi;
        below = fb < eff_lo;
        lossc = 26'(fb) < loss_thr;

        // start conditions of each timer
        cond[T_HW] = run && (hsel != pps_pkg::SEL_OFF) && above; // [RULE10] [RULE12]
        cond[T_HS] = run && (hsel == pps_pkg::SEL_BOTH) && above && s_q.hw; // [RULE11] [RULE12]
        cond[T_LW] = run && (lsel != pps_pkg::SEL_OFF) && below; // [RULE13] [RULE15]
        cond[T_LS] = run && (lsel == pps_pkg::SEL_BOTH) && below && s_q.lw; // [RULE14] [RULE15]
        cond[T_PL] = run && (psel != pps_pkg::SEL_OFF)
                     && (s_q.lossp != 10'h000) && lossc; // [RULE16] [RULE17]
        cond[T_SL] = run && !s_q.stop && (s_q.slp == SLP_WAIT); // [RULE4]

        // timers: clear when condition ends, saturate at limit
        for (int i = 0; i < 6; i++) begin
            expd[i] = cond[i] && (s_q.tmr[i] >= s_q.tlim[i]);
            if (!cond[i]) begin
                s_d.tmr[i] = 13'h0000; // [RULE20]
            end else if (tick && !expd[i]) begin
                s_d.tmr[i] = s_q.tmr[i] + 13'h0001; // [RULE20]
            end
        end

        // ========================================
        // apb slave: one wait-free access phase, data from flops
        setup  = apb_i.psel && !apb_i.penable;
        wr     = apb_i.psel && apb_i.penable && s_q.pready && apb_i.pwrite
                 && !s_q.pslverr;
        hit    = 1'b1;
        clr_ok = 1'b0;
        unique case (apb_i.paddr)
            pps_pkg::OFS_CTRL:  rd = {22'h000000, s_q.ctrl};
            pps_pkg::OFS_SETP:  rd = {16'h0000, s_q.setp};
            pps_pkg::OFS_MAXP:  rd = {16'h0000, s_q.maxp};
            pps_pkg::OFS_XFS:   rd = {16'h0000, s_q.xfs};
            pps_pkg::OFS_TOL:   rd = {16'h0000, s_q.tol};
            pps_pkg::OFS_SLPF:  rd = {16'h0000, s_q.slpf};
            pps_pkg::OFS_SLPT:  rd = {19'h00000, s_q.tlim[T_SL]};
            pps_pkg::OFS_HILIM: rd = {16'h0000, s_q.hilim};
            pps_pkg::OFS_LOLIM: rd = {16'h0000, s_q.lolim};
            pps_pkg::OFS_HIWT:  rd = {19'h00000, s_q.tlim[T_HW]};
            pps_pkg::OFS_HIST:  rd = {19'h00000, s_q.tlim[T_HS]};
            pps_pkg::OFS_LOWT:  rd = {19'h00000, s_q.tlim[T_LW]};
            pps_pkg::OFS_LOST:  rd = {19'h00000, s_q.tlim[T_LS]};
            pps_pkg::OFS_LOSST: rd = {19'h00000, s_q.tlim[T_PL]};
            pps_pkg::OFS_LOSSP: rd = {22'h000000, s_q.lossp};
            pps_pkg::OFS_GAIN:  rd = {2'h0, s_q.gain.td, s_q.gain.ti, s_q.gain.kp};
            pps_pkg::OFS_STAT:  rd = {22'h000000,
                                      (s_q.slp == SLP_WAIT), s_q.lower, s_q.raise,
                                      (s_q.slp == SLP_IDLE),
                                      s_q.pf, s_q.pw, s_q.lf, s_q.lw, s_q.hf, s_q.hw};
            default: begin
                // unmapped: zero data, error flagged
                rd  = 32'h00000000;
                hit = 1'b0;
            end
        endcase
        s_d.pready  = setup;
        s_d.pslverr = setup && !hit;
        s_d.prdata  = setup ? rd : s_q.prdata;

        // register writes take effect on the completing edge
        if (wr) begin
            unique case (apb_i.paddr)
                pps_pkg::OFS_CTRL:  s_d.ctrl  = wd[9:0];
                pps_pkg::OFS_SETP:  s_d.setp  = wd16;
                pps_pkg::OFS_MAXP:  s_d.maxp  = wd16;
                pps_pkg::OFS_XFS:   s_d.xfs   = wd16;
                pps_pkg::OFS_TOL:   s_d.tol   = wd16;
                // coarse step when the motor may exceed 300 hz
                pps_pkg::OFS_SLPF:  s_d.slpf  = s_q.ctrl[pps_pkg::CTL_FHI]
                                    ? wd16 - (wd16 % pps_pkg::FRES_HI) : wd16; // [RULE6]
                pps_pkg::OFS_SLPT:  s_d.tlim[T_SL] = wd[12:0];
                pps_pkg::OFS_HILIM: s_d.hilim = wd16;
                pps_pkg::OFS_LOLIM: s_d.lolim = wd16;
                pps_pkg::OFS_HIWT:  s_d.tlim[T_HW] = wd[12:0];
                pps_pkg::OFS_HIST:  s_d.tlim[T_HS] = wd[12:0];
                pps_pkg::OFS_LOWT:  s_d.tlim[T_LW] = wd[12:0];
                pps_pkg::OFS_LOST:  s_d.tlim[T_LS] = wd[12:0];
                pps_pkg::OFS_LOSST: s_d.tlim[T_PL] = wd[12:0];
                pps_pkg::OFS_LOSSP: s_d.lossp = wd[9:0];
                // no run interlock: gains apply at once
                pps_pkg::OFS_GAIN: begin
                    s_d.gain.kp = wd[pps_pkg::GAIN_KP +: 10];  // [RULE1]
                    s_d.gain.ti = wd[pps_pkg::GAIN_TI +: 10];  // [RULE1]
                    s_d.gain.td = wd[pps_pkg::GAIN_TD +: 10];  // [RULE1]
                end
                pps_pkg::OFS_STAT:  clr_ok = 1'b1;
                default: begin
                    // refused in setup already
                    clr_ok = 1'b0;
                end
            endcase
        end

        // ========================================
        // alarms; a set in the clearing cycle wins
        s_d.hw = (s_q.hw && cond[T_HW]) || expd[T_HW]; // [RULE10]
        s_d.lw = (s_q.lw && cond[T_LW]) || expd[T_LW]; // [RULE13]
        s_d.hf = (s_q.hf && !(clr_ok && wd[pps_pkg::ST_HF])) || expd[T_HS]; // [RULE11]
        s_d.lf = (s_q.lf && !(clr_ok && wd[pps_pkg::ST_LF])) || expd[T_LS]; // [RULE14]
        s_d.pw = (s_q.pw && !(clr_ok && wd[pps_pkg::ST_PW]))
                 || (expd[T_PL] && psel == pps_pkg::SEL_WARN); // [RULE18]
        s_d.pf = (s_q.pf && !(clr_ok && wd[pps_pkg::ST_PF]))
                 || (expd[T_PL] && psel == pps_pkg::SEL_BOTH); // [RULE17] [RULE18]
        s_d.stop = s_d.hf || s_d.lf || s_d.pf;

        // ========================================
        // sleep and wake sequencing
        unique case (s_q.slp)
            SLP_RUN: begin
                // pump-only sleep threshold
                if (out_freq_i < s_q.slpf) begin
                    s_d.slp = SLP_WAIT; // [RULE4] [RULE7]
                end
            end
            SLP_WAIT: begin
                if (out_freq_i >= s_q.slpf) begin
                    s_d.slp = SLP_RUN;
                end else if (expd[T_SL]) begin
                    s_d.slp = SLP_DECEL; // [RULE5]
                end
            end
            SLP_DECEL: begin
                // ramp on the normal deceleration time
                if (out_freq_i == 16'h0000) begin
                    s_d.slp = SLP_IDLE; // [RULE5]
                end
            end
            SLP_IDLE: begin
                if (fb < wake_lvl) begin
                    s_d.slp = SLP_RUN; // [RULE3]
                end
            end
        endcase
        if (!run || s_q.stop) begin
            s_d.slp = SLP_RUN;
        end

        // frequency direction commands
        s_d.lower = run && !s_q.stop && (fb > eff_sp)
                    && (s_q.slp != SLP_IDLE); // [RULE2]
        s_d.raise = run && !s_q.stop && (fb < wake_lvl)
                    && (s_q.slp != SLP_DECEL); // [RULE3]
        s_d.decel = run && !s_q.stop && (s_d.slp == SLP_DECEL); // [RULE5]

        // regulation target stays inside the limit band
        if (eff_sp > eff_hi) begin
            s_d.target = eff_hi; // [RULE8]
        end else if (eff_sp < eff_lo) begin
            s_d.target = eff_lo; // [RULE8]
        end else begin
            s_d.target = eff_sp;
        end
    end

    // ========================================
    // state register
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            s_q      <= '0;
            s_q.xfs  <= pps_pkg::RST_XFS;
            s_q.maxp <= pps_pkg::RST_MAXP;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================
    // outputs straight from flops, except pump_sleep_o, which is decoded from the sleep state flops
    assign prdata_o = s_q.prdata;
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign freq_lower_o = s_q.lower;
    assign freq_raise_o = s_q.raise;
    assign decel_sleep_o = s_q.decel;
    assign pump_sleep_o = (s_q.slp == SLP_IDLE);
    assign drive_stop_o = s_q.stop;
    assign reg_target_o = s_q.target;
    assign gain_o = s_q.gain;
    assign high_pressure_warning_flag_o = s_q.hw;
    assign high_pressure_stop_fault_o = s_q.hf;
    assign low_pressure_warning_flag_o = s_q.lw;
    assign low_pressure_stop_fault_o = s_q.lf;
    assign loss_warn_o = s_q.pw;
    assign loss_of_pressure_fault_o = s_q.pf;

endmodule : pps_supervisor

`default_nettype wire

/* File: dv/pps_plant.sv */
// behavioural output stage facing the pump pressure supervisor
// assumes the supervisor's commands are registered on the same clock
`timescale 1ns/1ns
`default_nettype none
module pps_plant #(
    parameter logic [15:0] STEP = 16'h0064  // ramp step, 1.00 hz per cycle
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // regulation commands
    input  wire logic        lower_i,
    input  wire logic        raise_i,
    input  wire logic        decel_i,
    // output stage
    output logic      [15:0] freq_o
);
    // ========================================
    // ramp, held inside 0 .. 50.00 hz so it never wraps
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            freq_o <= 16'h1388;
        end else if ((lower_i || decel_i) && freq_o >= STEP) begin
            freq_o <= freq_o - STEP;
        end else if (lower_i || decel_i) begin
            freq_o <= 16'h0000;
        end else if (raise_i && freq_o < 16'h1388) begin
            freq_o <= freq_o + STEP;
        end
    end
endmodule : pps_plant
`default_nettype wire

/* File: dv/pps_sup_chk.sv */
// port checker for the pump pressure supervisor
// assumes one clock domain; bound onto every supervisor instance
`timescale 1ns/1ns
`default_nettype none
module pps_sup_chk #(
    parameter int unsigned TICK_CYC = 4  // cycles per tick
) (
    // clock, reset and bus
    input wire logic                  core_clk_i,
    input wire logic                  rst_b_i,
    input wire pps_pkg::pps_apb_req_t apb_i,
    input wire logic                  pready_o,
    // regulation
    input wire logic                  freq_lower_o,
    input wire logic                  freq_raise_o,
    input wire logic                  decel_sleep_o,
    input wire logic                  pump_sleep_o,
    input wire logic                  drive_stop_o,
    input wire pps_pkg::pps_gain_t    gain_o,
    // alarms
    input wire logic                  high_pressure_warning_flag_o,
    input wire logic                  high_pressure_stop_fault_o,
    input wire logic                  low_pressure_warning_flag_o,
    input wire logic                  low_pressure_stop_fault_o,
    input wire logic                  loss_of_pressure_fault_o
);
    // ========================================
    // committed writes, seen at the pready edge
    wire logic wr_c = apb_i.psel & apb_i.penable & apb_i.pwrite & pready_o;
    wire logic wr_gain = wr_c & (apb_i.paddr == pps_pkg::OFS_GAIN);
    wire logic clr_hf = wr_c & (apb_i.paddr == pps_pkg::OFS_STAT) & apb_i.pwdata[1];

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // ========================================
    // assertions
    property p_gain;
        wr_gain |=> gain_o == {$past(apb_i.pwdata[9:0]), $past(apb_i.pwdata[19:10]),
            $past(apb_i.pwdata[29:20])};
    endproperty
    a_gain: assert property (p_gain) else $error("gain mirror wrong");
    property p_stop;
        drive_stop_o == (high_pressure_stop_fault_o | low_pressure_stop_fault_o
            | loss_of_pressure_fault_o);
    endproperty
    a_stop: assert property (p_stop) else $error("stop not tied to faults");
    property p_hfw;
        $rose(high_pressure_stop_fault_o) |-> $past(high_pressure_warning_flag_o);
    endproperty
    a_hfw: assert property (p_hfw) else $error("high fault without warning");
    property p_lfw;
        $rose(low_pressure_stop_fault_o) |-> $past(low_pressure_warning_flag_o);
    endproperty
    a_lfw: assert property (p_lfw) else $error("low fault without warning");
    property p_excl;
        !(freq_lower_o && freq_raise_o);
    endproperty
    a_excl: assert property (p_excl) else $error("raise and lower together");
    property p_gate;
        drive_stop_o && $past(drive_stop_o) |-> !freq_raise_o && !freq_lower_o;
    endproperty
    a_gate: assert property (p_gate) else $error("regulation during fault");
    property p_sleep;
        $rose(pump_sleep_o) |-> $past(decel_sleep_o);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep without ramp");
    property p_hold;
        $past(high_pressure_stop_fault_o) && !$past(clr_hf) |-> high_pressure_stop_fault_o;
    endproperty
    a_hold: assert property (p_hold) else $error("high fault lost");
endmodule : pps_sup_chk
bind pps_supervisor pps_sup_chk #(.TICK_CYC(TICK_CYC)) pps_sup_chk_i (.*);
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the pump pressure supervisor
// assumes pps_pkg, the plant model and the checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    typedef struct packed {
        logic [15:0] ctrl;  // control word
        logic [15:0] prop;  // loss proportion
        logic [15:0] fb;    // feedback held
        logic [5:0]  st;    // expected alarm bits
    } pps_row_t;
    logic                  core_clk_i, rst_b_i, pready_o, pslverr_o, err;
    pps_pkg::pps_apb_req_t apb_i;
    logic [31:0]           prdata_o, rd;
    logic [15:0]           fb_press_i, out_freq_i, reg_target_o;
    logic                  freq_lower_o, freq_raise_o, decel_sleep_o, pump_sleep_o;
    logic                  drive_stop_o, loss_warn_o, loss_of_pressure_fault_o;
    logic                  high_pressure_warning_flag_o, high_pressure_stop_fault_o;
    logic                  low_pressure_warning_flag_o, low_pressure_stop_fault_o;
    pps_pkg::pps_gain_t    gain_o;
    int                    n_fail = 0, checks = 0, cyc = 0, k;
    // setpoint 5.00, tolerance 0.50, limits 8.00 / 2.00, short timers
    logic [7:0]  ca [10] = '{pps_pkg::OFS_SETP, pps_pkg::OFS_TOL, pps_pkg::OFS_HILIM,
        pps_pkg::OFS_LOLIM, pps_pkg::OFS_HIWT, pps_pkg::OFS_HIST, pps_pkg::OFS_LOWT,
        pps_pkg::OFS_LOST, pps_pkg::OFS_LOSST, pps_pkg::OFS_SLPT};
    logic [15:0] cd [10] = '{16'h01f4, 16'h0032, 16'h0320, 16'h00c8, 16'h0002,
        16'h0002, 16'h0002, 16'h0002, 16'h0003, 16'h0002};
    pps_row_t rows [13] = '{
        '{16'h0001, 16'h01f4, 16'h0384, 6'h00}, '{16'h0011, 16'h01f4, 16'h0384, 6'h01},
        '{16'h0021, 16'h01f4, 16'h0384, 6'h03}, '{16'h0031, 16'h01f4, 16'h0384, 6'h01},
        '{16'h0020, 16'h01f4, 16'h0384, 6'h00}, '{16'h0001, 16'h01f4, 16'h0064, 6'h00},
        '{16'h0041, 16'h01f4, 16'h0064, 6'h04}, '{16'h0081, 16'h01f4, 16'h0064, 6'h0c},
        '{16'h0101, 16'h01f4, 16'h0064, 6'h10}, '{16'h0201, 16'h01f4, 16'h0064, 6'h20},
        '{16'h0201, 16'h0000, 16'h0064, 6'h00}, '{16'h0201, 16'h01f4, 16'h012c, 6'h00},
        '{16'h0013, 16'h01f4, 16'h0190, 6'h01}};

    pps_supervisor #(.TICK_CYC(4)) pps_supervisor_i (.*);
    pps_plant pps_plant_i (.clk_i(core_clk_i), .rst_b_i(rst_b_i), .lower_i(freq_lower_o),
        .raise_i(freq_raise_o), .decel_i(decel_sleep_o), .freq_o(out_freq_i));

    // ========================================
    // one apb transfer, held until pready is sampled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge core_clk_i);
        apb_i.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 16);
        if (k == 16) n_fail++;
        rd = prdata_o;
        err = pslverr_o;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
    endtask : xfer

    task automatic complete_run();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    // ========================================
    // clock and hang guard
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    // ========================================
    // main sequence
    initial begin
        rst_b_i = 1'b0;
        apb_i = '0;
        fb_press_i = 16'h01f4;
        repeat (5) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        xfer(0, pps_pkg::OFS_XFS, 0);
        `CHK(rd, 32'h000003e8)
        xfer(0, 8'h44, 0);
        `CHK({err, rd}, 33'h100000000)
        foreach (ca[i]) xfer(1, ca[i], {16'h0000, cd[i]});
        // alarm selections, units and loss detection
        foreach (rows[i]) begin
            xfer(1, pps_pkg::OFS_LOSSP, {16'h0000, rows[i].prop});
            xfer(1, pps_pkg::OFS_CTRL, {16'h0000, rows[i].ctrl});
            fb_press_i <= rows[i].fb;
            repeat (60) @(posedge core_clk_i);
            xfer(0, pps_pkg::OFS_STAT, 0);
            `CHK(rd[5:0], rows[i].st)
            `CHK(drive_stop_o, |(rows[i].st & 6'h2a))
            fb_press_i <= 16'h01f4;
            xfer(1, pps_pkg::OFS_CTRL, 32'h1);
            xfer(1, pps_pkg::OFS_STAT, 32'h3f);
            repeat (20) @(posedge core_clk_i);
        end
        // gains rewritten while running
        xfer(1, pps_pkg::OFS_GAIN, 32'h03232064);
        @(posedge core_clk_i);
        `CHK(gain_o, {10'h064, 10'h0c8, 10'h032})
        // short excursions restart the warning timer
        xfer(1, pps_pkg::OFS_CTRL, 32'h11);
        repeat (4) begin
            fb_press_i <= 16'h0384;
            repeat (3) @(posedge core_clk_i);
            fb_press_i <= 16'h01f4;
            repeat (3) @(posedge core_clk_i);
        end
        repeat (4) @(posedge core_clk_i);
        `CHK(high_pressure_warning_flag_o, 1'b0)
        fb_press_i <= 16'h0384;
        repeat (20) @(posedge core_clk_i);
        `CHK(high_pressure_warning_flag_o, 1'b1)
        fb_press_i <= 16'h01f4;
        repeat (5) @(posedge core_clk_i);
        `CHK(high_pressure_warning_flag_o, 1'b0)
        // target clamps: to max pressure, then up to the low limit
        `CHK(reg_target_o, 16'h01f4)
        xfer(1, pps_pkg::OFS_MAXP, 32'h258);
        xfer(1, pps_pkg::OFS_SETP, 32'h384);
        repeat (2) @(posedge core_clk_i);
        `CHK(reg_target_o, 16'h0258)
        xfer(1, pps_pkg::OFS_SETP, 32'h64);
        repeat (2) @(posedge core_clk_i);
        `CHK(reg_target_o, 16'h00c8)
        xfer(1, pps_pkg::OFS_MAXP, 32'h3e8);
        xfer(1, pps_pkg::OFS_SETP, 32'h1f4);
        // lower, time the sleep delay, ramp down, sleep, then wake
        xfer(1, pps_pkg::OFS_CTRL, 32'h5);
        fb_press_i <= 16'h0258;
        repeat (6) @(posedge core_clk_i);
        `CHK(freq_lower_o, 1'b1)
        xfer(1, pps_pkg::OFS_SLPF, 32'h4d2);
        xfer(0, pps_pkg::OFS_SLPF, 0);
        `CHK(rd, 32'h000004ce)
        repeat (300) if (pump_sleep_o !== 1'b1) @(posedge core_clk_i);
        `CHK({pump_sleep_o, out_freq_i}, 17'h10000)
        fb_press_i <= 16'h0190;
        repeat (40) if (freq_raise_o !== 1'b1) @(posedge core_clk_i);
        `CHK({freq_raise_o, pump_sleep_o}, 2'b10)
        complete_run();
    end
endmodule : tb
`default_nettype wire
